/* design/asr_pkg.sv */
// package: constants, register map and carrier types of the addressable shift register
package asr_pkg;
  // ==========================================================
  // chain geometry
  localparam int STAGES = 32;
  localparam int UNITS = 4;
  localparam int UNIT_AW = 5;
  localparam int CHAIN_AW = 7;
  localparam logic [STAGES-1:0] STAGES_RESET = 32'h0000_0000;
  // ==========================================================
  // input buffer
  localparam int BUF_DEPTH = 2;
  localparam int BUF_WIDTH = 1;
  localparam logic [1:0] BUF_COUNT_RESET = 2'h0;
  localparam logic [1:0] BUF_FULL_COUNT = 2'h2;
  // ==========================================================
  // bus encodings and register offsets
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_TAP = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam logic [31:0] ADDR_COUNT = 32'h0000_000C;
  localparam logic [CHAIN_AW-1:0] TAP_RESET = 7'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // ==========================================================
  // carrier types
  typedef struct packed {
    logic casc_reg;
    logic tap_reg;
    logic shift_en;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = 3'h0;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } ahb_phase_t;
  localparam ahb_phase_t PHASE_RESET = 34'h0_0000_0000;
  typedef struct packed {
    logic [1:0] buf_count;
    logic cascade;
    logic tap;
  } status_t;
endpackage : asr_pkg

/* design/shift_core.sv */
// one 32-stage addressable shift unit with optional output flops
module shift_core
  import asr_pkg::*;
#(
  parameter bit FALLING_EDGE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic d,
  input wire logic [UNIT_AW-1:0] addr,
  input wire logic tap_reg,
  input wire logic casc_reg,
  input wire logic global_init,
  output logic q,
  output logic last_bit,
  output logic casc_q
);
  logic act_clk;
  logic [STAGES-1:0] stages;
  logic tap_comb;
  logic tap_ff;
  logic casc_ff;

  // ==========================================================
  // active edge selection
  assign act_clk = clk_sys ^ FALLING_EDGE;

  // shift chain, untouched by global_init
  always_ff @(posedge act_clk or negedge arst_n) begin
    if (!arst_n) begin
      stages <= STAGES_RESET;
    end else if (ce) begin
      stages <= {stages[STAGES-2:0], d};
    end
  end

  // addressed read, no clock in the path
  assign tap_comb = stages[addr];
  assign last_bit = stages[STAGES-1];

  // output flops act as one more stage
  always_ff @(posedge act_clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_ff <= 1'b0;
      casc_ff <= 1'b0;
    end else if (ce) begin
      tap_ff <= tap_comb;
      casc_ff <= last_bit;
    end
  end

  assign q = tap_reg ? tap_ff : tap_comb;
  assign casc_q = casc_reg ? casc_ff : last_bit;

  // ==========================================================
  // checks
  default clocking cb @(posedge act_clk); endclocking
  default disable iff (!arst_n);

  AST_HOLD: assert property (!ce |=> stages == $past(stages))
    else $error("contents moved without enable");
  AST_SHIFT: assert property (ce |=> stages == {$past(stages[STAGES-2:0]), $past(d)})
    else $error("enabled shift wrong");
  AST_TAP_END: assert property (addr == 5'h1F |-> tap_comb == last_bit)
    else $error("tap at last stage differs from cascade");
  AST_CASC: assert property (ce ##1 ce |=> last_bit == $past(stages[STAGES-3], 2))
    else $error("cascade not last stage");
  AST_CASC_NEW: assert property (ce |=> last_bit == $past(stages[STAGES-2]))
    else $error("cascade not updated after shift");
  AST_INIT: assert property (global_init && !ce |=> $stable(stages))
    else $error("global init touched contents");
  AST_DELAY: assert property (
    ce && addr == 5'h01 ##1 ce && addr == 5'h01 |=> tap_comb == $past(d, 2))
    else $error("delay not address plus one");
  AST_TAP_FF: assert property (tap_reg && ce ##1 tap_reg |-> q == $past(tap_comb))
    else $error("registered tap wrong");
  AST_CASC_FF: assert property (casc_reg && ce ##1 casc_reg |-> casc_q == $past(last_bit))
    else $error("registered cascade wrong");
  AST_LIVE: assert property (addr == 5'h00 && !tap_reg && ce |=> q == $past(d))
    else $error("tap not combinational");
  COV_SHIFT: cover property (ce [*4]);
  COV_TAP_FF: cover property (tap_reg && ce ##1 ce);
endmodule : shift_core

/* design/addressable_shift_reg.sv */
// top: chained addressable shift register with input buffer and bus registers
// Functional notes
// - with enable low nothing shifts and up to two serial bits wait in the input buffer.
// - an enabled edge loads the serial bit into stage 0 and moves every bit one stage on.
// - the tap output shows the stage selected by the tap address, 0 to 31 per unit.
// - with the cascade flop off, the cascade output is the last stage, whatever the address.
// - with the cascade flop off, after each enabled shift the cascade output carries the new last-stage bit.
// - an instance parameter picks the rising or falling edge, rising by default.
// - the global init signal leaves the stored bits alone.
// - the delay from serial input to tap is the address plus one.
// - an optional tap flop on the same edge forms the last stage, address is length minus two.
// - an optional flop on the same edge may register the cascade output.
// - four units chain with a unit select to give up to 128 stages.
module addressable_shift_reg
  import asr_pkg::*;
#(
  parameter bit FALLING_EDGE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_valid,
  input wire logic in_bit,
  output logic in_ready,
  input wire logic global_init,
  output logic tap_out,
  output logic cascade_out
);
  // ==========================================================
  // declarations
  ahb_phase_t phase;
  ctrl_t ctrl;
  logic [CHAIN_AW-1:0] tap_addr;
  logic [31:0] shift_count;
  status_t status;
  logic [BUF_WIDTH-1:0] buf_mem [BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] buf_count;
  logic buf_valid;
  logic push;
  logic ce;
  logic [BUF_WIDTH-1:0] buf_data;
  logic unit_d [UNITS];
  logic unit_q [UNITS];
  logic unit_last [UNITS];
  logic unit_casc [UNITS];
  logic wr_hit;

  // ==========================================================
  // bus slave: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase <= PHASE_RESET;
    end else if (hready) begin
      phase.valid <= hsel && htrans == HTRANS_NONSEQ;
      phase.write <= hwrite;
      phase.addr <= haddr;
    end
  end

  assign wr_hit = phase.valid && phase.write;

  // control register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RESET;
    end else if (wr_hit && phase.addr == ADDR_CTRL) begin
      ctrl <= hwdata[2:0];
    end
  end

  // tap address register, high bits pick the unit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tap_addr <= TAP_RESET;
    end else if (wr_hit && phase.addr == ADDR_TAP) begin
      tap_addr <= hwdata[CHAIN_AW-1:0];
    end
  end

  // count of enabled shifts, read only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shift_count <= COUNT_RESET;
    end else if (ce) begin
      shift_count <= shift_count + COUNT_STEP;
    end
  end

  // status snapshot of buffer fill level and live outputs
  assign status.buf_count = buf_count;
  assign status.cascade = cascade_out;
  assign status.tap = tap_out;

  // read mux during data phase, unmapped reads zero
  function automatic logic [31:0] reg_read(
    input logic [31:0] a,
    input ctrl_t c,
    input logic [CHAIN_AW-1:0] t,
    input status_t s,
    input logic [31:0] n
  );
    logic [31:0] r;
    r = RDATA_ZERO;
    unique case (a)
      ADDR_CTRL: r = {29'h0000_0000, c};
      ADDR_TAP: r = {25'h000_0000, t};
      ADDR_STATUS: r = {28'h000_0000, s};
      ADDR_COUNT: r = n;
      default: r = RDATA_ZERO;
    endcase
    return r;
  endfunction : reg_read

  assign hrdata = (phase.valid && !phase.write) ?
    reg_read(phase.addr, ctrl, tap_addr, status, shift_count) : RDATA_ZERO;

  // ==========================================================
  // two-entry input buffer
  assign in_ready = buf_count != BUF_FULL_COUNT;
  assign push = in_valid && in_ready;
  assign buf_valid = buf_count != BUF_COUNT_RESET;
  assign buf_data = buf_mem[rd_ptr];

  // drain only while shifting is enabled
  assign ce = buf_valid && ctrl.shift_en;

  // buffer storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      buf_mem[wr_ptr] <= in_bit;
    end
  end

  // buffer pointers and fill level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      buf_count <= BUF_COUNT_RESET;
    end else begin
      if (push) begin
        wr_ptr <= !wr_ptr;
      end
      if (ce) begin
        rd_ptr <= !rd_ptr;
      end
      if (push && !ce) begin
        buf_count <= buf_count + 2'h1;
      end else if (ce && !push) begin
        buf_count <= buf_count - 2'h1;
      end
    end
  end

  // ==========================================================
  // unit chain: last stage of one feeds the next, cascade flop not in the link
  assign unit_d[0] = buf_data[0];

  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    if (u > 0) begin : g_link
      assign unit_d[u] = unit_last[u-1];
    end
    shift_core #(
      .FALLING_EDGE(FALLING_EDGE)
    ) u_core (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .ce(ce),
      .d(unit_d[u]),
      .addr(tap_addr[UNIT_AW-1:0]),
      .tap_reg(ctrl.tap_reg),
      .casc_reg(ctrl.casc_reg),
      .global_init(global_init),
      .q(unit_q[u]),
      .last_bit(unit_last[u]),
      .casc_q(unit_casc[u])
    );
  end

  // unit select for the tap, last unit drives cascade
  assign tap_out = unit_q[tap_addr[CHAIN_AW-1:UNIT_AW]];
  assign cascade_out = unit_casc[UNITS-1];

  // ==========================================================
  // checks
  AST_CHAIN: assert property (@(posedge clk_sys) disable iff (!arst_n || FALLING_EDGE)
    tap_addr == 7'h20 && !ctrl.tap_reg && ce |=> tap_out == $past(unit_last[0]))
    else $error("chain link between units broken");
  AST_CE_GATE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !ctrl.shift_en |=> shift_count == $past(shift_count))
    else $error("shift counted while disabled");
  AST_FULL: assert property (@(posedge clk_sys) disable iff (!arst_n)
    in_valid && !ctrl.shift_en && buf_count == 2'h1 |=> !in_ready ##1 !in_ready)
    else $error("buffer did not stall when full");
  AST_NO_LOSS: assert property (@(posedge clk_sys) disable iff (!arst_n)
    push && !ce |=> buf_count == $past(buf_count) + 2'h1)
    else $error("pushed bit lost");
  COV_FULL: cover property (@(posedge clk_sys) disable iff (!arst_n) !in_ready);
  COV_CHAIN: cover property (@(posedge clk_sys) disable iff (!arst_n)
    tap_addr[6:5] == 2'h3 && ce);
  COV_WRITE_CTRL: cover property (@(posedge clk_sys) disable iff (!arst_n)
    wr_hit && phase.addr == ADDR_CTRL);
endmodule : addressable_shift_reg

/* verification/bit_source.sv */
// partner model: user logic offering serial bits over valid and ready
module bit_source (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic go,
  input wire logic [6:0] n,
  input wire logic [63:0] pat,
  input wire logic stall,
  input wire logic in_ready,
  output logic in_valid,
  output logic in_bit,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] left;
  logic [63:0] sr;
  assign busy = in_valid || (left != 7'h00);
  // one new bit per handshake, held until taken
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      in_valid <= 1'b0;
      in_bit <= 1'b0;
      left <= 7'h00;
      sr <= 64'h0000_0000_0000_0000;
    end else if (go) begin
      left <= n;
      sr <= pat;
    end else if (!in_valid || in_ready) begin
      if (left != 7'h00 && !stall) begin
        in_valid <= 1'b1;
        in_bit <= sr[0];
        sr <= sr >> 1;
        left <= left - 7'h01;
      end else begin
        in_valid <= 1'b0;
        in_bit <= ~in_bit; // stale line does not keep its value
      end
    end
  end
endmodule : bit_source

/* verification/tb_addressable_shift_reg.sv */
// testbench: bus reads checked against a model of the 128-stage chain
module tb_addressable_shift_reg import asr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic global_init = 1'b0, stall = 1'b0, rd_phase = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, in_ready, in_valid, in_bit, tap_out, cascade_out, busy;
  logic [6:0] n = 7'h00;
  logic [63:0] pat = 64'h0000_0000_0000_0000;
  logic [128:0] m;
  logic [6:0] a;
  logic [6:0] taps [4] = '{7'h00, 7'h1F, 7'h20, 7'h7F};
  logic [31:0] exp_q [$];
  int fails = 0, comparisons = 0, cycles = 0, seed = 32'h011a6698;

  always #4 clk_sys = ~clk_sys;

  addressable_shift_reg u_addressable_shift_reg (.clk_sys, .arst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .in_valid,
    .in_bit, .in_ready, .global_init, .tap_out, .cascade_out);
  bit_source u_bit_source (.clk_sys, .arst_n, .go, .n, .pat, .stall, .in_ready, .in_valid,
    .in_bit, .busy);

  // ==========================================================
  // tasks
  task give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task check_word(input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] hrdata expected %h seen %h", e, s);
    end
  endtask : check_word
  // single transfer; for a read d is the expected word
  task bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= !w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd_phase <= 1'b0;
  endtask : bus
  task send(input int k, input logic [63:0] p);
    n <= 7'(k);
    pat <= p;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    for (int i = 0; i < k; i++) m = {m[127:0], p[i]};
  endtask : send
  task settle;
    @(posedge clk_sys); // let the source take the new count first
    while (busy === 1'b1) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
  endtask : settle

  // ==========================================================
  // monitor, random stalls and init toggling, timeout
  always @(posedge clk_sys) begin
    cycles++;
    if (rd_phase) check_word(exp_q.pop_front(), hrdata);
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end
  always @(posedge clk_sys) begin
    stall <= 1'($random(seed));
    global_init <= 1'($random(seed));
  end

  // ==========================================================
  // main sequence
  initial begin
    m = {129{1'b0}};
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) bus(1'b0, 32'(i * 4), 32'h0000_0000);
    bus(1'b1, 32'h0000_0010, 32'h0000_0001);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    $display("test reset values done");
    send(3, 64'h0000_0000_0000_0005);
    repeat (4) @(posedge clk_sys);
    bus(1'b0, ADDR_STATUS, 32'h0000_0008);
    bus(1'b0, ADDR_COUNT, 32'h0000_0000);
    bus(1'b1, ADDR_CTRL, 32'h0000_0001);
    settle();
    bus(1'b0, ADDR_COUNT, 32'h0000_0003);
    $display("test stall and drain done");
    for (int r = 0; r < 3; r++) begin
      send(40, {$random(seed), $random(seed)});
      settle();
    end
    for (int i = 0; i < 12; i++) begin
      a = (i < 4) ? taps[i] : 7'($random(seed));
      bus(1'b1, ADDR_TAP, {25'h000_0000, a});
      bus(1'b0, ADDR_STATUS, {30'h0000_0000, m[127], m[a]});
    end
    bus(1'b0, ADDR_COUNT, 32'h0000_007B);
    $display("test tap sweep done");
    bus(1'b1, ADDR_TAP, 32'h0000_0005);
    bus(1'b1, ADDR_CTRL, 32'h0000_0007);
    send(1, 64'h0000_0000_0000_0001);
    settle();
    bus(1'b0, ADDR_STATUS, {30'h0000_0000, m[128], m[6]});
    $display("test output flops done");
    give_verdict();
  end
endmodule : tb_addressable_shift_reg
